// File: verilog/hbc_regs.svh
// register offsets, fields, resets and timing of the buck current loop
//
// Functional notes
// - DAC peak threshold ends each on-time
// - PI off-time, then turn on, sample valley
// - period mean is half of peak plus valley
// - valley samples averaged every 16 cycles
// - reference minus average drives PI off-time
// - four gain shifts: range times startup/normal
// - soft-start ramps from start current by steps
// - time step counted in 100 us ticks
// - zero start step skips ramp, full current
// - soft shutdown lowers reference by steps
// - bounded error current held, then zero
// - zero shutdown step means no ramp down
// - ripple loop interval, startup and normal
// - steady after programmed ripple loop passes
// - four current groups share limits
// - group initial percent, absolute min/max ripple
// - frequency limits held as period limits
// - peak/valley are reference plus/minus half ripple
// - too fast: raise ripple up to maximum
// - too slow: lower ripple down to minimum
`ifndef HBC_REGS_SVH
`define HBC_REGS_SVH
`define HBC_CTRL_OFS 8'h00
`define HBC_REF_OFS 8'h04
`define HBC_SS_OFS 8'h08
`define HBC_SD_OFS 8'h0C
`define HBC_ERR_OFS 8'h10
`define HBC_PI_OFS 8'h14
`define HBC_FRC_OFS 8'h18
`define HBC_STAT_OFS 8'h1C
`define HBC_STAT2_OFS 8'h50
`define HBC_STAT3_OFS 8'h54
`define HBC_GRIP_PAGE 4'h2
`define HBC_GPER_PAGE 4'h3
`define HBC_GPCT_PAGE 4'h4
`define HBC_HI_LSB 16
`define HBC_GRP_LSB 30
`define HBC_CSTEP_LSB 16
`define HBC_TSTEP_LSB 24
`define HBC_SDT_LSB 8
`define HBC_ETIME_LSB 16
`define HBC_FRC_NORM_LSB 8
`define HBC_FRC_STDY_LSB 16
`define HBC_REG_RST 32'h0000_0000
`define HBC_TOFF_RST 16'h0040
`define HBC_TOFF_MIN 16'h0004
`define HBC_RIP_STEP 12'h001
`define HBC_PCT_DIV 20'h0_0064
`define HBC_AVG_LOG2 4
`define HBC_CLK_MHZ 125
`define HBC_TICK_US 100
`define HBC_TICK_CYC (`HBC_TICK_US * `HBC_CLK_MHZ)
`endif

// File: verilog/hbc_pkg.sv
// types of the buck current loop
package hbc_pkg;
  typedef enum logic [2:0] {
    HBC_IDLE,
    HBC_RAMP_UP,
    HBC_RUN,
    HBC_RAMP_DOWN,
    HBC_ERR_HOLD
  } hbc_mode_t;
  typedef logic [11:0] hbc_cur_t;
endpackage

// File: verilog/hbc_pi.sv
// pi off-time regulator
`timescale 1ns/10ps
`default_nettype none
`include "hbc_regs.svh"
module hbc_pi #(
  parameter logic [15:0] TOFF_INIT = `HBC_TOFF_RST,
  parameter logic [15:0] TOFF_MIN  = `HBC_TOFF_MIN
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               err_stb,
  input  wire logic signed [13:0] err,
  input  wire logic [3:0]         gain_shift,
  output logic [15:0]             toff
);
  logic signed [13:0] err_prev_reg;
  logic [15:0]        toff_reg;
  logic signed [17:0] prop;
  logic signed [17:0] integ;
  logic signed [17:0] toff_next;

  assign prop      = (18'(err) - 18'(err_prev_reg)) >>> gain_shift;
  assign integ     = 18'(err) >>> (5'(gain_shift) + 5'h02);
  assign toff_next = $signed({2'b00, toff_reg}) - prop - integ;
  assign toff      = toff_reg;

  // positive error means too little current: shorten off-time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toff_reg     <= TOFF_INIT;
      err_prev_reg <= 14'h0000;
    end else if (err_stb) begin
      err_prev_reg <= err;
      if (toff_next < $signed({2'b00, TOFF_MIN})) begin
        toff_reg <= TOFF_MIN;
      end else if (toff_next > 18'sh0_FFFF) begin
        toff_reg <= 16'hFFFF;
      end else begin
        toff_reg <= toff_next[15:0];
      end
    end
  end

  toff_floor_a: assert property (@(posedge pclk) disable iff (!presetn)
    err_stb |=> toff_reg >= TOFF_MIN)
    else $error("off-time below floor");
endmodule
`default_nettype wire

// File: verilog/hbc_core.sv
// hysteretic buck current loop with apb registers
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "hbc_regs.svh"
module hbc_core #(
  parameter int TICK_CYCLES = `HBC_TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmp_peak_hit,
  input  wire logic [11:0] adc_current,
  input  wire logic        supply_weak,
  output logic             gate_on,
  output logic [12:0]      peak_code
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  logic [31:0]        ctrl_reg, ref_reg, ss_reg, sd_reg;
  logic [31:0]        err_reg, pi_reg, frc_reg;
  logic [31:0]        grp_rip_reg [4];
  logic [31:0]        grp_per_reg [4];
  logic [7:0]         grp_pct_reg [4];
  logic [31:0]        prdata_reg, rd_next;
  logic               pready_reg, pslverr_reg, rd_hit, wr_en;
  hbc_pkg::hbc_mode_t mode_reg;
  hbc_pkg::hbc_cur_t  iref_reg, ripple_reg, valley_reg, avg_reg, mean_reg;
  logic [12:0]        dac_reg, peak_sum, avg_mean;
  logic [11:0]        valley_tgt;
  logic [TW-1:0]      tick_cnt_reg;
  logic               tick;
  logic [7:0]         step_cnt_reg, frc_cnt_reg, pass_cnt_reg, frc_intv;
  logic [15:0]        hold_cnt_reg, off_cnt_reg, per_cnt_reg, per_meas_reg;
  logic               gate_reg, run, off_done, on_stb, steady_reg;
  logic [3:0]         cyc_cnt_reg, gain_shift;
  logic [15:0]        acc_reg, acc_sum, toff_val;
  logic               avg_stb_reg;
  logic signed [13:0] err_val;
  logic [1:0]         grp;
  logic [19:0]        rip_raw;
  logic [11:0]        rip_init, g_rmin, g_rmax;
  logic [15:0]        g_long, g_short;

  // field views
  logic [11:0] ref_cur, hcth, ss_start, err_min, err_max;
  logic [7:0]  ss_cstep, ss_tstep, sd_cstep, sd_tstep;
  logic [15:0] err_time;
  assign ref_cur  = ref_reg[11:0];
  assign hcth     = ref_reg[`HBC_HI_LSB +: 12];
  assign grp      = ref_reg[`HBC_GRP_LSB +: 2];
  assign ss_start = ss_reg[11:0];
  assign ss_cstep = ss_reg[`HBC_CSTEP_LSB +: 8];
  assign ss_tstep = ss_reg[`HBC_TSTEP_LSB +: 8];
  assign sd_cstep = sd_reg[7:0];
  assign sd_tstep = sd_reg[`HBC_SDT_LSB +: 8];
  assign err_time = sd_reg[`HBC_ETIME_LSB +: 16];
  assign err_min  = err_reg[11:0];
  assign err_max  = err_reg[`HBC_HI_LSB +: 12];
  assign g_rmin   = grp_rip_reg[grp][11:0];
  assign g_rmax   = grp_rip_reg[grp][`HBC_HI_LSB +: 12];
  assign g_long   = grp_per_reg[grp][15:0];
  assign g_short  = grp_per_reg[grp][`HBC_HI_LSB +: 16];

  // apb slave, zero wait states
  assign wr_en   = psel && penable && pwrite && pready_reg;
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  always_comb begin
    rd_next = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (paddr == `HBC_CTRL_OFS) begin
      rd_next = ctrl_reg;
    end else if (paddr == `HBC_REF_OFS) begin
      rd_next = ref_reg;
    end else if (paddr == `HBC_SS_OFS) begin
      rd_next = ss_reg;
    end else if (paddr == `HBC_SD_OFS) begin
      rd_next = sd_reg;
    end else if (paddr == `HBC_ERR_OFS) begin
      rd_next = err_reg;
    end else if (paddr == `HBC_PI_OFS) begin
      rd_next = pi_reg;
    end else if (paddr == `HBC_FRC_OFS) begin
      rd_next = frc_reg;
    end else if (paddr == `HBC_STAT_OFS) begin
      rd_next = {steady_reg, mode_reg, ripple_reg, 4'h0, iref_reg};
    end else if (paddr == `HBC_STAT2_OFS) begin
      rd_next = {toff_val, per_meas_reg};
    end else if (paddr == `HBC_STAT3_OFS) begin
      rd_next = {4'h0, valley_tgt, 4'h0, mean_reg};
    end else if (paddr[7:4] == `HBC_GRIP_PAGE && paddr[1:0] == 2'b00) begin
      rd_next = grp_rip_reg[paddr[3:2]];
    end else if (paddr[7:4] == `HBC_GPER_PAGE && paddr[1:0] == 2'b00) begin
      rd_next = grp_per_reg[paddr[3:2]];
    end else if (paddr[7:4] == `HBC_GPCT_PAGE && paddr[1:0] == 2'b00) begin
      rd_next = {24'h00_0000, grp_pct_reg[paddr[3:2]]};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= `HBC_REG_RST;
    end else begin
      pready_reg  <= psel && !penable;
      pslverr_reg <= psel && !penable && !rd_hit;
      if (psel && !penable) begin
        prdata_reg <= rd_next;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `HBC_REG_RST;
      ref_reg  <= `HBC_REG_RST;
      ss_reg   <= `HBC_REG_RST;
      sd_reg   <= `HBC_REG_RST;
      err_reg  <= `HBC_REG_RST;
      pi_reg   <= `HBC_REG_RST;
      frc_reg  <= `HBC_REG_RST;
    end else if (wr_en) begin
      if (paddr == `HBC_CTRL_OFS) begin
        ctrl_reg <= {31'h0000_0000, pwdata[0]};
      end else if (paddr == `HBC_REF_OFS) begin
        ref_reg <= pwdata;
      end else if (paddr == `HBC_SS_OFS) begin
        ss_reg <= pwdata;
      end else if (paddr == `HBC_SD_OFS) begin
        sd_reg <= pwdata;
      end else if (paddr == `HBC_ERR_OFS) begin
        err_reg <= pwdata;
      end else if (paddr == `HBC_PI_OFS) begin
        pi_reg <= pwdata;
      end else if (paddr == `HBC_FRC_OFS) begin
        frc_reg <= pwdata;
      end
    end
  end

  // per-group limit registers
  for (genvar g = 0; g < 4; g++) begin : g_grp
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        grp_rip_reg[g] <= `HBC_REG_RST;
        grp_per_reg[g] <= `HBC_REG_RST;
        grp_pct_reg[g] <= 8'h00;
      end else if (wr_en && paddr[3:2] == 2'(g) && paddr[1:0] == 2'b00) begin
        if (paddr[7:4] == `HBC_GRIP_PAGE) begin
          grp_rip_reg[g] <= pwdata;
        end else if (paddr[7:4] == `HBC_GPER_PAGE) begin
          grp_per_reg[g] <= pwdata;
        end else if (paddr[7:4] == `HBC_GPCT_PAGE) begin
          grp_pct_reg[g] <= pwdata[7:0];
        end
      end
    end
  end

  // system tick
  assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TW'(1);
    end
  end

  // reference current sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg     <= hbc_pkg::HBC_IDLE;
      iref_reg     <= 12'h000;
      step_cnt_reg <= 8'h00;
      hold_cnt_reg <= 16'h0000;
    end else begin
      case (mode_reg)
        hbc_pkg::HBC_IDLE: begin
          step_cnt_reg <= 8'h00;
          hold_cnt_reg <= 16'h0000;
          if (ctrl_reg[0]) begin
            if (ss_cstep == 8'h00 || ss_tstep == 8'h00) begin
              iref_reg <= ref_cur;
              mode_reg <= hbc_pkg::HBC_RUN;
            end else begin
              iref_reg <= (ss_start < ref_cur) ? ss_start : ref_cur;
              mode_reg <= hbc_pkg::HBC_RAMP_UP;
            end
          end
        end
        hbc_pkg::HBC_RAMP_UP, hbc_pkg::HBC_RUN: begin
          if (!ctrl_reg[0]) begin
            step_cnt_reg <= 8'h00;
            if (sd_cstep == 8'h00 || sd_tstep == 8'h00) begin
              iref_reg <= 12'h000;
              mode_reg <= hbc_pkg::HBC_IDLE;
            end else begin
              mode_reg <= hbc_pkg::HBC_RAMP_DOWN;
            end
          end else if (mode_reg == hbc_pkg::HBC_RUN) begin
            iref_reg <= ref_cur;
          end else if (tick) begin
            if (8'(step_cnt_reg + 8'h01) >= ss_tstep) begin
              step_cnt_reg <= 8'h00;
              if (13'(iref_reg) + 13'(ss_cstep) >= 13'(ref_cur)) begin
                iref_reg <= ref_cur;
                mode_reg <= hbc_pkg::HBC_RUN;
              end else begin
                iref_reg <= 12'(iref_reg + 12'(ss_cstep));
              end
            end else begin
              step_cnt_reg <= step_cnt_reg + 8'h01;
            end
          end
        end
        hbc_pkg::HBC_RAMP_DOWN: begin
          if (supply_weak) begin
            mode_reg     <= hbc_pkg::HBC_ERR_HOLD;
            hold_cnt_reg <= 16'h0000;
            if (iref_reg > err_max) begin
              iref_reg <= err_max;
            end else if (iref_reg < err_min) begin
              iref_reg <= err_min;
            end
          end else if (tick) begin
            if (8'(step_cnt_reg + 8'h01) >= sd_tstep) begin
              step_cnt_reg <= 8'h00;
              if (iref_reg > 12'(sd_cstep)) begin
                iref_reg <= iref_reg - 12'(sd_cstep);
              end else begin
                iref_reg <= 12'h000;
                mode_reg <= hbc_pkg::HBC_IDLE;
              end
            end else begin
              step_cnt_reg <= step_cnt_reg + 8'h01;
            end
          end
        end
        hbc_pkg::HBC_ERR_HOLD: begin
          if (tick) begin
            if (16'(hold_cnt_reg + 16'h0001) >= err_time) begin
              iref_reg <= 12'h000;
              mode_reg <= hbc_pkg::HBC_IDLE;
            end else begin
              hold_cnt_reg <= hold_cnt_reg + 16'h0001;
            end
          end
        end
        default: begin
          mode_reg <= hbc_pkg::HBC_IDLE;
        end
      endcase
    end
  end

  // hysteresis thresholds
  assign peak_sum   = 13'(iref_reg) + 13'(ripple_reg[11:1]);
  assign valley_tgt = (iref_reg > ripple_reg[11:1]) ? iref_reg - ripple_reg[11:1] : 12'h000;
  assign peak_code  = dac_reg;
  assign gate_on    = gate_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_reg <= 13'h0000;
    end else begin
      dac_reg <= peak_sum;
    end
  end

  // switch control
  assign run      = (mode_reg != hbc_pkg::HBC_IDLE) && (iref_reg != 12'h000);
  assign off_done = (16'(off_cnt_reg + 16'h0001) >= toff_val);
  assign on_stb   = run && !gate_reg && off_done;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_reg    <= 1'b0;
      off_cnt_reg <= 16'h0000;
    end else if (!run) begin
      gate_reg    <= 1'b0;
      off_cnt_reg <= 16'h0000;
    end else if (gate_reg) begin
      if (cmp_peak_hit) begin
        gate_reg    <= 1'b0;
        off_cnt_reg <= 16'h0000;
      end
    end else if (off_done) begin
      gate_reg <= 1'b1;
    end else begin
      off_cnt_reg <= off_cnt_reg + 16'h0001;
    end
  end

  // period measurement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_reg  <= 16'h0000;
      per_meas_reg <= 16'h0000;
    end else if (!run) begin
      per_cnt_reg  <= 16'h0000;
      per_meas_reg <= 16'h0000;
    end else if (on_stb) begin
      per_cnt_reg  <= 16'h0000;
      per_meas_reg <= 16'(per_cnt_reg + 16'h0001);
    end else if (per_cnt_reg != 16'hFFFF) begin
      per_cnt_reg <= per_cnt_reg + 16'h0001;
    end
  end

  // valley sampling and averaging
  assign acc_sum = acc_reg + 16'(adc_current);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valley_reg  <= 12'h000;
      mean_reg    <= 12'h000;
      acc_reg     <= 16'h0000;
      cyc_cnt_reg <= 4'h0;
      avg_reg     <= 12'h000;
      avg_stb_reg <= 1'b0;
    end else begin
      avg_stb_reg <= 1'b0;
      if (on_stb) begin
        valley_reg  <= adc_current;
        mean_reg    <= 12'((14'(dac_reg) + 14'(adc_current)) >> 1);
        cyc_cnt_reg <= cyc_cnt_reg + 4'h1;
        if (cyc_cnt_reg == 4'hF) begin
          avg_reg     <= 12'(acc_sum >> `HBC_AVG_LOG2);
          acc_reg     <= 16'h0000;
          avg_stb_reg <= 1'b1;
        end else begin
          acc_reg <= acc_sum;
        end
      end
    end
  end

  // loop error and gain selection
  assign avg_mean = 13'((14'(dac_reg) + 14'(avg_reg)) >> 1);
  assign err_val  = $signed(14'(iref_reg)) - $signed(14'(avg_mean));
  always_comb begin
    case ({steady_reg, iref_reg > hcth})
      2'b00:   gain_shift = pi_reg[3:0];
      2'b01:   gain_shift = pi_reg[7:4];
      2'b10:   gain_shift = pi_reg[11:8];
      default: gain_shift = pi_reg[15:12];
    endcase
  end

  hbc_pi u_pi (
    .pclk       (pclk),
    .presetn    (presetn),
    .err_stb    (avg_stb_reg),
    .err        (err_val),
    .gain_shift (gain_shift),
    .toff       (toff_val)
  );

  // frequency_ripple_loop
  assign rip_raw  = (20'(ref_cur) * 20'(grp_pct_reg[grp])) / `HBC_PCT_DIV;
  assign rip_init = (rip_raw > 20'(g_rmax)) ? g_rmax :
                    (rip_raw < 20'(g_rmin)) ? g_rmin : rip_raw[11:0];
  assign frc_intv = steady_reg ? frc_reg[`HBC_FRC_NORM_LSB +: 8] : frc_reg[7:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frc_cnt_reg  <= 8'h00;
      pass_cnt_reg <= 8'h00;
      ripple_reg   <= 12'h000;
    end else if (mode_reg == hbc_pkg::HBC_IDLE) begin
      frc_cnt_reg  <= 8'h00;
      pass_cnt_reg <= 8'h00;
      ripple_reg   <= rip_init;
    end else if (tick && frc_intv != 8'h00) begin
      if (8'(frc_cnt_reg + 8'h01) >= frc_intv) begin
        frc_cnt_reg <= 8'h00;
        if (pass_cnt_reg != 8'hFF) begin
          pass_cnt_reg <= pass_cnt_reg + 8'h01;
        end
        if (per_meas_reg != 16'h0000 && per_meas_reg < g_short) begin
          ripple_reg <= (13'(ripple_reg) + 13'(`HBC_RIP_STEP) >= 13'(g_rmax)) ?
                        g_rmax : 12'(ripple_reg + `HBC_RIP_STEP);
        end else if (per_meas_reg > g_long) begin
          ripple_reg <= (ripple_reg <= 12'(g_rmin + `HBC_RIP_STEP)) ?
                        g_rmin : 12'(ripple_reg - `HBC_RIP_STEP);
        end
      end else begin
        frc_cnt_reg <= frc_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      steady_reg <= 1'b0;
    end else begin
      steady_reg <= (mode_reg != hbc_pkg::HBC_IDLE) &&
                    (pass_cnt_reg >= frc_reg[`HBC_FRC_STDY_LSB +: 8]);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  peak_turn_off_a: assert property (gate_reg && cmp_peak_hit |=> !gate_reg)
    else $error("switch not off at peak");
  off_hold_a: assert property (run && !gate_reg && !off_done |=> !gate_reg)
    else $error("switch on before off-time");
  valley_take_a: assert property ($rose(gate_reg) |-> valley_reg == $past(adc_current))
    else $error("valley not sampled at turn-on");
  avg_sixteen_a: assert property (avg_stb_reg |-> $past(cyc_cnt_reg) == 4'hF)
    else $error("average not on sixteenth cycle");
  ramp_skip_a: assert property (mode_reg == hbc_pkg::HBC_IDLE && ctrl_reg[0]
    && ss_cstep == 8'h00 |=> mode_reg == hbc_pkg::HBC_RUN && iref_reg == $past(ref_cur))
    else $error("soft-start not skipped");
  sd_skip_a: assert property (mode_reg == hbc_pkg::HBC_RUN && !ctrl_reg[0]
    && sd_tstep == 8'h00 |=> mode_reg == hbc_pkg::HBC_IDLE && iref_reg == 12'h000)
    else $error("shutdown ramp not skipped");
  err_bound_a: assert property (mode_reg == hbc_pkg::HBC_RAMP_DOWN && supply_weak
    && err_min <= err_max |=> iref_reg <= err_max && iref_reg >= err_min)
    else $error("error current out of bounds");
  steady_pass_a: assert property ($rose(steady_reg) |->
    $past(pass_cnt_reg) >= $past(frc_reg[`HBC_FRC_STDY_LSB +: 8]))
    else $error("steady before pass count");
  rip_ceiling_a: assert property (mode_reg != hbc_pkg::HBC_IDLE && ripple_reg <= g_rmax
    && $stable(grp) && $stable(g_rmax) |=> ripple_reg <= g_rmax)
    else $error("ripple above maximum");
  peak_track_a: assert property ($stable(iref_reg) && $stable(ripple_reg) |->
    dac_reg == 13'(iref_reg) + 13'(ripple_reg[11:1]))
    else $error("peak threshold wrong");
endmodule
`default_nettype wire

// File: tb/hbc_stage_model.sv
// power stage model: inductor current, shunt and comparator
`timescale 1ns/10ps
`default_nettype none
module hbc_stage_model #(
  parameter int RISE = 6,
  parameter int FALL = 2
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        gate_on,
  input  wire logic [12:0] peak_code,
  output logic             cmp_peak_hit,
  output logic [11:0]      adc_current
);
  logic [12:0] cur_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= 13'h0000;
    end else if (gate_on) begin
      cur_reg <= cur_reg + 13'(RISE);
    end else if (cur_reg > 13'(FALL)) begin
      cur_reg <= cur_reg - 13'(FALL);
    end else begin
      cur_reg <= 13'h0000;
    end
  end
  assign cmp_peak_hit = cur_reg >= peak_code;
  assign adc_current  = cur_reg[11:0];
endmodule
`default_nettype wire

// File: tb/hbc_core_tb.sv
// self-checking bench of the buck current loop
`timescale 1ns/10ps
`default_nettype none
`include "hbc_regs.svh"
module hbc_core_tb;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cmp_peak_hit;
  logic [11:0] adc_current;
  logic        supply_weak = 1'h0;
  logic        gate_on;
  logic [12:0] peak_code;
  logic [31:0] rd;
  logic        rerr;
  logic [11:0] valley;
  int          n_errors = 0;
  int          checks_done = 0;

  always #4 pclk = ~pclk;

  hbc_core #(.TICK_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_peak_hit(cmp_peak_hit),
    .adc_current(adc_current), .supply_weak(supply_weak), .gate_on(gate_on),
    .peak_code(peak_code));
  hbc_stage_model pwr (.clk(pclk), .rst_n(presetn), .gate_on(gate_on),
    .peak_code(peak_code), .cmp_peak_hit(cmp_peak_hit), .adc_current(adc_current));

  task automatic end_of_test();
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic give_up();
    n_errors++;
    end_of_test();
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, idle cycle first
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (n >= 16) give_up();
    rd = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wait_leave(input logic [2:0] m);
    int n;
    n = 0;
    do begin
      apb(1'h0, `HBC_STAT_OFS, 32'h0000_0000);
      n++;
    end while (rd[30:28] === m && n < 400);
    if (n >= 400) give_up();
  endtask

  task automatic wait_peak(output int n);
    logic [12:0] p;
    p = peak_code;
    n = 0;
    while (peak_code === p && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) give_up();
  endtask

  task automatic run_while(input logic v, output int n);
    n = 0;
    while (gate_on === v && n < 4000) begin
      valley = adc_current;
      @(posedge pclk);
      n++;
    end
    if (n >= 4000) give_up();
  endtask

  initial begin
    int          n;
    int          non;
    logic [12:0] pk;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk({gate_on, peak_code}, 32'h0000_0000);
    apb(1'h0, `HBC_REF_OFS, 32'h0000_0000);
    chk(rd, `HBC_REG_RST);
    apb(1'h0, 8'hFC, 32'h0000_0000);
    chk({rerr, rd[30:0]}, 32'h8000_0000);
    apb(1'h1, `HBC_STAT_OFS, 32'hFFFF_FFFF);
    apb(1'h0, `HBC_STAT_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'h1, `HBC_REF_OFS, 32'h0190_012C);
    apb(1'h1, 8'h20, 32'h00C8_0014);
    apb(1'h1, 8'h40, 32'h0000_001E);
    apb(1'h1, `HBC_PI_OFS, 32'h0000_FFFF);
    apb(1'h1, `HBC_SS_OFS, 32'h0232_0064);
    apb(1'h1, `HBC_SD_OFS, 32'h0004_0132);
    apb(1'h1, `HBC_ERR_OFS, 32'h0050_0028);
    apb(1'h0, `HBC_REF_OFS, 32'h0000_0000);
    chk(rd, 32'h0190_012C);
    apb(1'h1, `HBC_CTRL_OFS, 32'h0000_0001);
    wait_leave(hbc_pkg::HBC_IDLE);
    chk({rd[30:28], rd[11:0]}, {hbc_pkg::HBC_RAMP_UP, 12'h064});
    wait_peak(n);
    pk = peak_code;
    wait_peak(n);
    chk(n, 16);
    chk(peak_code - pk, 13'h0032);
    wait_leave(hbc_pkg::HBC_RAMP_UP);
    chk(rd[30:0], {hbc_pkg::HBC_RUN, 16'h05A0, 12'h12C});
    chk(peak_code, 13'h0159);
    run_while(1'h1, n);
    run_while(1'h0, n);
    pk = peak_code;
    run_while(1'h1, non);
    run_while(1'h0, n);
    chk(n, 64);
    apb(1'h0, `HBC_STAT2_OFS, 32'h0000_0000);
    chk(rd, {`HBC_TOFF_RST, 16'(non + n)});
    apb(1'h0, `HBC_STAT3_OFS, 32'h0000_0000);
    chk(rd[11:0], 12'((14'(pk) + 14'(valley)) >> 1));
    apb(1'h1, `HBC_CTRL_OFS, 32'h0000_0000);
    wait_leave(hbc_pkg::HBC_RUN);
    chk(rd[30:28], hbc_pkg::HBC_RAMP_DOWN);
    pk = peak_code;
    wait_peak(n);
    chk(pk - peak_code, 13'h0032);
    supply_weak <= 1'h1;
    wait_leave(hbc_pkg::HBC_RAMP_DOWN);
    chk({rd[30:28], rd[11:0]}, {hbc_pkg::HBC_ERR_HOLD, 12'h050});
    wait_leave(hbc_pkg::HBC_ERR_HOLD);
    chk({rd[30:28], rd[11:0]}, {hbc_pkg::HBC_IDLE, 12'h000});
    supply_weak <= 1'h0;
    apb(1'h1, `HBC_SS_OFS, 32'h0000_0064);
    apb(1'h1, `HBC_SD_OFS, 32'h0000_0000);
    apb(1'h1, `HBC_FRC_OFS, 32'h0003_0101);
    apb(1'h1, 8'h30, 32'hFFFF_FFFF);
    apb(1'h1, `HBC_CTRL_OFS, 32'h0000_0001);
    wait_leave(hbc_pkg::HBC_IDLE);
    chk({rd[30:28], rd[11:0]}, {hbc_pkg::HBC_RUN, 12'h12C});
    chk(rd[31], 1'h0);
    repeat (2000) @(posedge pclk);
    apb(1'h0, `HBC_STAT_OFS, 32'h0000_0000);
    chk(rd[31], 1'h1);
    chk(rd[27:16], 12'h0C8);
    apb(1'h1, 8'h30, 32'h0000_0001);
    repeat (2000) @(posedge pclk);
    apb(1'h0, `HBC_STAT_OFS, 32'h0000_0000);
    chk(rd[27:16], 12'h014);
    apb(1'h1, `HBC_CTRL_OFS, 32'h0000_0000);
    wait_leave(hbc_pkg::HBC_RUN);
    chk({rd[30:28], rd[11:0]}, {hbc_pkg::HBC_IDLE, 12'h000});
    end_of_test();
  end
endmodule
`default_nettype wire
